// ### shared/cipher_consts.vh
// Constants of the AES-128 cipher control block
`ifndef CIPHER_CONSTS_VH
`define CIPHER_CONSTS_VH

// SRAM window locations
`define ADDR_STATUS     8'h82
`define ADDR_CTRL       8'h83
`define ADDR_BLK_FIRST  8'h84
`define ADDR_BLK_LAST   8'h93
`define ADDR_CTRL_COPY  8'h94

// Control byte fields
`define CTRL_REQ_BIT    7
`define CTRL_MODE_HI    6
`define CTRL_MODE_LO    4
`define CTRL_DIR_BIT    3
`define MODE_ECB        3'h0
`define MODE_KEY        3'h1
`define MODE_CBC        3'h2

// Status byte fields
`define STAT_DONE_BIT   0
`define STAT_ERR_BIT    1

// Timing
`define CLK_PERIOD_NS   10
`define RUN_MAX_NS      24000
`define RUN_MAX_CYCLES  12'h960

// Cipher core constants
`define ROUND_FIRST     4'h1
`define ROUND_LAST      4'hA
`define RCON_ENC_FIRST  8'h01
`define RCON_DEC_FIRST  8'h36
`define GF_POLY         8'h1B
`define GF_ONE          8'h01
`define SBOX_FWD_C      8'h63
`define SBOX_INV_C      8'h05
`define BYTE_ZERO       8'h00
`define BLOCK_ZERO      128'h0

`endif

// ### src/aes_sbox.v
// AES byte substitution, forward or inverse, by field inversion and affine map
`timescale 1ns/1ps
`include "cipher_consts.vh"

module aes_sbox
(
  // Control
  input  wire       inv,
  // Byte in and out
  input  wire [7:0] din,
  output wire [7:0] dout
);

  // Multiply in GF(2^8); a table would cost more area for two directions
  function [7:0] gmul;
    input [7:0] a;
    input [7:0] b;
    reg   [7:0] p;
    reg   [7:0] x;
    integer     i;
    begin
      p = `BYTE_ZERO;
      x = a;
      for (i = 0; i < 8; i = i + 1)
      begin
        if (b[i])
          p = p ^ x;
        x = x[7] ? ({x[6:0], 1'b0} ^ `GF_POLY) : {x[6:0], 1'b0};
      end
      gmul = p;
    end
  endfunction

  // Inverse as a^254; zero maps to zero as the cipher expects
  function [7:0] ginv;
    input [7:0] a;
    reg   [7:0] p;
    reg   [7:0] r;
    integer     k;
    begin
      p = a;
      r = `GF_ONE;
      for (k = 1; k < 8; k = k + 1)
      begin
        p = gmul(p, p);
        r = gmul(r, p);
      end
      ginv = r;
    end
  endfunction

  wire [7:0] pre;
  wire [7:0] g;

  // Inverse affine before inversion, forward affine after it
  assign pre  = inv ? ({din[6:0], din[7]} ^ {din[4:0], din[7:5]} ^
                       {din[1:0], din[7:2]} ^ `SBOX_INV_C) : din;
  assign g    = ginv(pre);
  assign dout = inv ? g : (g ^ {g[6:0], g[7]} ^ {g[5:0], g[7:6]} ^
                           {g[4:0], g[7:5]} ^ {g[3:0], g[7:4]} ^ `SBOX_FWD_C);

endmodule // aes_sbox

// ### src/aes_round_core.v
// Iterative AES-128 core, one round per clock, key schedule run on the fly
`timescale 1ns/1ps
`include "cipher_consts.vh"

module aes_round_core
(
  // Clock and clear
  input  wire         mclk,
  input  wire         clear,
  // Run request
  input  wire         start,
  input  wire         dir,
  input  wire [127:0] key_in,
  input  wire [127:0] data_in,
  // Result
  output reg          busy_q,
  output reg          done_q,
  output reg  [127:0] st_q,
  output reg  [127:0] rk_q
);

  // Doubling in GF(2^8)
  function [7:0] xt;
    input [7:0] a;
    begin
      xt = a[7] ? ({a[6:0], 1'b0} ^ `GF_POLY) : {a[6:0], 1'b0};
    end
  endfunction

  // Forward column mix
  function [31:0] mixcol;
    input [31:0] c;
    reg   [7:0]  a0, a1, a2, a3, t;
    begin
      {a0, a1, a2, a3} = c;
      t = a0 ^ a1 ^ a2 ^ a3;
      mixcol = {a0 ^ t ^ xt(a0 ^ a1), a1 ^ t ^ xt(a1 ^ a2),
                a2 ^ t ^ xt(a2 ^ a3), a3 ^ t ^ xt(a3 ^ a0)};
    end
  endfunction

  // Pre-step that turns the forward mix into the inverse mix
  function [31:0] invpre;
    input [31:0] c;
    reg   [7:0]  a0, a1, a2, a3, u, v;
    begin
      {a0, a1, a2, a3} = c;
      u = xt(xt(a0 ^ a2));
      v = xt(xt(a1 ^ a3));
      invpre = {a0 ^ u, a1 ^ v, a2 ^ u, a3 ^ v};
    end
  endfunction

  reg  [7:0]   rcon_q;
  reg  [3:0]   round_q;
  wire [127:0] sh;
  wire [127:0] sb;
  wire [127:0] rnd_out;
  wire [127:0] rk_next;
  wire [31:0]  sw;
  wire         last;
  wire [31:0]  w0, w1, w2, w3, p3, kw, t;
  wire [7:0]   rx;

  assign last = (round_q == `ROUND_LAST);

  // ***********************************************************************
  // Row shift and substitution per byte
  // ***********************************************************************
  genvar j;
  generate
    for (j = 0; j < 16; j = j + 1)
    begin : g_byte
      localparam integer R  = j % 4;
      localparam integer C  = j / 4;
      localparam integer SE = 4 * ((C + R) % 4) + R;
      localparam integer SD = 4 * ((C + 4 - R) % 4) + R;
      assign sh[127-8*j -: 8] = dir ? st_q[127-8*SD -: 8] : st_q[127-8*SE -: 8];
      aes_sbox u_sb (.inv(dir), .din(sh[127-8*j -: 8]), .dout(sb[127-8*j -: 8]));
    end
  endgenerate

  // ***********************************************************************
  // Key schedule, forward for encryption and backward for decryption
  // ***********************************************************************
  assign {w0, w1, w2, w3} = rk_q;
  assign p3 = w3 ^ w2;
  assign kw = dir ? p3 : w3;
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1)
    begin : g_key
      // Word rotation: output byte k is fed from byte k+1 of the source word
      aes_sbox u_ks
      (
        .inv  (1'b0),
        .din  (kw[31-8*((k+1)%4) -: 8]),
        .dout (sw[31-8*k -: 8])
      );
    end
  endgenerate
  assign t       = sw ^ {rcon_q, 24'h000000};
  assign rk_next = dir ? {w0 ^ t, w1 ^ w0, w2 ^ w1, p3}
                       : {w0 ^ t, w1 ^ w0 ^ t, w2 ^ w1 ^ w0 ^ t, w3 ^ w2 ^ w1 ^ w0 ^ t};
  assign rx      = rcon_q ^ `GF_POLY;

  // ***********************************************************************
  // Column mix and round key addition
  // ***********************************************************************
  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1)
    begin : g_col
      wire [31:0] sc = sb[127-32*c -: 32];
      wire [31:0] kc = rk_next[127-32*c -: 32];
      wire [31:0] ec = (last ? sc : mixcol(sc)) ^ kc;
      wire [31:0] dc = sc ^ kc;
      assign rnd_out[127-32*c -: 32] = dir ? (last ? dc : mixcol(invpre(dc))) : ec;
    end
  endgenerate

  // Round sequencer; ten rounds run far inside the allowed run time
  always @(posedge mclk)
  begin
    if (clear)
    begin
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      st_q    <= `BLOCK_ZERO;
      rk_q    <= `BLOCK_ZERO;
      rcon_q  <= `BYTE_ZERO;
      round_q <= 4'h0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start && !busy_q)
      begin
        st_q    <= data_in ^ key_in;
        rk_q    <= key_in;
        rcon_q  <= dir ? `RCON_DEC_FIRST : `RCON_ENC_FIRST;
        round_q <= `ROUND_FIRST;
        busy_q  <= 1'b1;
      end
      else if (busy_q)
      begin
        st_q    <= rnd_out;
        rk_q    <= rk_next;
        rcon_q  <= dir ? (rcon_q[0] ? {1'b1, rx[7:1]} : {1'b0, rcon_q[7:1]}) : xt(rcon_q);
        round_q <= round_q + 4'h1;
        if (last)
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

endmodule // aes_round_core

// ### src/cipher_control.v
// AES-128 control block: SRAM window decode, key and block pages, run control
`timescale 1ns/1ps
`include "cipher_consts.vh"

module cipher_control
(
  // Clock and reset
  input  wire       mclk,
  input  wire       rst,
  // Power state of the transceiver
  input  wire       sleep_state,
  // SRAM-style byte access from the SPI engine
  input  wire       acc_begin,
  input  wire [7:0] acc_addr,
  input  wire       acc_write,
  input  wire       byte_strobe,
  input  wire [7:0] wr_byte,
  // Answers
  output reg  [7:0] rd_byte_q,
  output reg        run_busy_q,
  output reg        run_done_q
);

  localparam [11:0] RUN_LIMIT = `RUN_MAX_CYCLES;

  // ***********************************************************************
  // Storage
  // ***********************************************************************
  reg  [7:0]   ptr_q;
  reg          wr_q;
  reg  [2:0]   mode_q;
  reg          dir_q;
  reg          err_q;
  reg          start_q;
  reg          chain_ok_q;
  reg  [11:0]  run_cnt_q;
  reg  [127:0] key_init_q;
  reg  [127:0] key_last_q;
  reg  [127:0] blk_q;
  reg  [127:0] prev_ct_q;
  reg  [7:0]   rd_mux;

  wire         wipe;
  wire         in_blk;
  wire         in_ctrl;
  wire         in_win;
  wire [7:0]   blk_off;
  wire [3:0]   idx;
  wire         wr_ok;
  wire         ctrl_wr;
  wire         blk_wr;
  wire [2:0]   wmode;
  wire         wdir;
  wire         legal;
  wire         req_set;
  wire         req_bad;
  wire [127:0] core_data_in;
  wire         core_busy;
  wire         core_done;
  wire [127:0] core_data;
  wire [127:0] core_key;
  wire         run_timeout;

  // Sleep acts like reset on every piece of state here
  assign wipe = rst | sleep_state;

  // ***********************************************************************
  // Window decode
  // ***********************************************************************
  // Only the SRAM window reaches these locations
  assign in_blk  = (ptr_q >= `ADDR_BLK_FIRST) && (ptr_q <= `ADDR_BLK_LAST);
  assign in_ctrl = (ptr_q == `ADDR_CTRL) || (ptr_q == `ADDR_CTRL_COPY);
  assign in_win  = (ptr_q >= `ADDR_STATUS) && (ptr_q <= `ADDR_CTRL_COPY);
  assign blk_off = ptr_q - `ADDR_BLK_FIRST;
  assign idx     = blk_off[3:0];

  // Writes need an open write access, a window hit and an awake device
  assign wr_ok   = byte_strobe && wr_q && in_win && !sleep_state;
  assign ctrl_wr = wr_ok && in_ctrl;
  // Block page is frozen while a run works on it
  assign blk_wr  = wr_ok && in_blk && !run_busy_q && !core_busy;

  // ***********************************************************************
  // Start decision
  // ***********************************************************************
  assign wmode   = wr_byte[`CTRL_MODE_HI:`CTRL_MODE_LO];
  assign wdir    = wr_byte[`CTRL_DIR_BIT];
  // CBC decryption and a request in key mode are not runnable
  assign legal   = (wmode == `MODE_ECB) || ((wmode == `MODE_CBC) && !wdir);
  assign req_set = ctrl_wr && wr_byte[`CTRL_REQ_BIT] && !run_busy_q && legal;
  assign req_bad = ctrl_wr && wr_byte[`CTRL_REQ_BIT] && !run_busy_q && !legal;

  // Chaining folds in the last encryption result of any mode; a block run before any encryption has ended since wipe runs plain
  assign core_data_in = ((mode_q == `MODE_CBC) && chain_ok_q) ?
                        (blk_q ^ prev_ct_q) : blk_q;

  assign run_timeout = run_busy_q && (run_cnt_q >= RUN_LIMIT);

  // ***********************************************************************
  // Access pointer
  // ***********************************************************************
  // Address auto-increments so one access can span control, block and copy
  always @(posedge mclk)
  begin
    if (wipe)
    begin
      ptr_q <= `BYTE_ZERO;
      wr_q  <= 1'b0;
    end
    else if (acc_begin)
    begin
      ptr_q <= acc_addr;
      wr_q  <= acc_write;
    end
    else if (byte_strobe)
    begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // ***********************************************************************
  // Read path
  // ***********************************************************************
  // Key locations show the written key until a run ends, then the final round key (the cipher key after decryption); key_init_q is read only by the core
  always @*
  begin
    rd_mux = `BYTE_ZERO;
    if (ptr_q == `ADDR_STATUS)
      rd_mux = {6'h00, err_q, run_done_q};
    else if (in_ctrl)
      rd_mux = {run_busy_q, mode_q, dir_q, 3'h0};
    else if (in_blk)
      rd_mux = (mode_q == `MODE_KEY) ? key_last_q[127-8*idx -: 8]
                                     : blk_q[127-8*idx -: 8];
  end

  // Old content is captured before the same strobe overwrites it, so the
  // SPI engine shifts it out one byte behind the incoming data
  always @(posedge mclk)
  begin
    if (wipe)
      rd_byte_q <= `BYTE_ZERO;
    else if (byte_strobe)
      rd_byte_q <= rd_mux;
  end

  // ***********************************************************************
  // Control location and its copy
  // ***********************************************************************
  // Mode and direction change only while idle so a run sees stable settings
  always @(posedge mclk)
  begin
    if (wipe)
    begin
      mode_q  <= `MODE_ECB;
      dir_q   <= 1'b0;
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= req_set;
      if (ctrl_wr && !run_busy_q)
      begin
        mode_q <= wmode;
        dir_q  <= wdir;
      end
    end
  end

  // ***********************************************************************
  // Key pages
  // ***********************************************************************
  // The initial key is written only by the host
  always @(posedge mclk)
  begin
    if (wipe)
    begin
      key_init_q <= `BLOCK_ZERO;
      key_last_q <= `BLOCK_ZERO;
    end
    else
    begin
      if (blk_wr && (mode_q == `MODE_KEY))
      begin
        key_init_q[127-8*idx -: 8] <= wr_byte;
        key_last_q[127-8*idx -: 8] <= wr_byte;
      end
      else if (core_done)
      begin
        key_last_q <= core_key;
      end
    end
  end

  // ***********************************************************************
  // Block page and chaining
  // ***********************************************************************
  // Result replaces the input in place; a later write replaces the result
  always @(posedge mclk)
  begin
    if (wipe)
    begin
      blk_q      <= `BLOCK_ZERO;
      prev_ct_q  <= `BLOCK_ZERO;
      chain_ok_q <= 1'b0;
    end
    else
    begin
      if (blk_wr && (mode_q != `MODE_KEY))
        blk_q[127-8*idx -: 8] <= wr_byte;
      else if (core_done)
        blk_q <= core_data;
      if (core_done && !dir_q)
      begin
        prev_ct_q  <= core_data;
        chain_ok_q <= 1'b1;
      end
    end
  end

  // ***********************************************************************
  // Run supervision
  // ***********************************************************************
  // Request bit reads back as busy until the core reports completion
  always @(posedge mclk)
  begin
    if (wipe)
    begin
      run_busy_q <= 1'b0;
      run_done_q <= 1'b0;
      err_q      <= 1'b0;
      run_cnt_q  <= 12'h000;
    end
    else if (req_set)
    begin
      run_busy_q <= 1'b1;
      run_done_q <= 1'b0;
      err_q      <= 1'b0;
      run_cnt_q  <= 12'h000;
    end
    else if (req_bad)
    begin
      err_q <= 1'b1;
    end
    else if (core_done)
    begin
      run_busy_q <= 1'b0;
      run_done_q <= 1'b1;
    end
    else if (run_timeout)
    begin
      // Guard only; the core ends in a dozen cycles
      run_busy_q <= 1'b0;
      err_q      <= 1'b1;
    end
    else if (run_busy_q)
    begin
      run_cnt_q <= run_cnt_q + 12'h001;
    end
  end

  // ***********************************************************************
  // Cipher core
  // ***********************************************************************
  // No radio signal enters the core, so runs overlap frame traffic freely
  aes_round_core u_core
  (
    .mclk    (mclk),
    .clear   (wipe),
    .start   (start_q),
    .dir     (dir_q),
    .key_in  (key_init_q),
    .data_in (core_data_in),
    .busy_q  (core_busy),
    .done_q  (core_done),
    .st_q    (core_data),
    .rk_q    (core_key)
  );

endmodule // cipher_control

// ### tb/host_model.sv
// Host model: SRAM-style byte accesses into the cipher window
`timescale 1ns/1ps
`include "cipher_consts.vh"

module host_model
(
  // Clock
  input  wire logic       mclk,
  // Access request
  output logic            acc_begin,
  output logic [7:0]      acc_addr,
  output logic            acc_write,
  output logic            byte_strobe,
  output logic [7:0]      wr_byte,
  // Answer
  input  wire logic [7:0] rd_byte_q
);
  // Idle bus at time zero
  initial
  begin
    acc_begin   = 1'b0;
    acc_addr    = 8'h00;
    acc_write   = 1'b0;
    byte_strobe = 1'b0;
    wr_byte     = 8'h00;
  end

  // One access: begin pulse, then n strobes back to back, first byte in the top of wb
  task automatic access(input logic [7:0] addr, input logic wr, input int n,
                        input logic [159:0] wb, output logic [159:0] rb);
    rb = 160'h0;
    @(negedge mclk);
    acc_begin = 1'b1;
    acc_addr  = addr;
    acc_write = wr;
    for (int i = 0; i < n; i++)
    begin
      @(negedge mclk);
      acc_begin = 1'b0;
      if (i > 0)
        rb = {rb[151:0], rd_byte_q};
      byte_strobe = 1'b1;
      wr_byte     = wb[159 - 8*i -: 8];
    end
    @(negedge mclk);
    rb          = {rb[151:0], rd_byte_q};
    byte_strobe = 1'b0;
    wr_byte     = ~wr_byte; // Released line must not keep the last byte
  endtask

  // Key mode first, then the key, in one access so nothing can run in between
  task automatic load_key(input logic [127:0] key);
    logic [159:0] rb;
    access(`ADDR_CTRL, 1'b1, 17, {8'h10, key, 24'h0}, rb);
  endtask
endmodule // host_model

// ### tb/cipher_control_checker.sv
// Checker: port-level assertions for the cipher control block
`timescale 1ns/1ps
`include "cipher_consts.vh"

module cipher_control_checker
(
  // Clock and reset
  input wire       mclk,
  input wire       rst,
  input wire       sleep_state,
  // Access
  input wire       acc_begin,
  input wire [7:0] acc_addr,
  input wire       acc_write,
  input wire       byte_strobe,
  input wire [7:0] wr_byte,
  // Answers
  input wire [7:0] rd_byte_q,
  input wire       run_busy_q,
  input wire       run_done_q
);
  reg  [7:0] ptr_q;
  reg        wr_q;
  wire       ctrl_hit = (ptr_q == `ADDR_CTRL) || (ptr_q == `ADDR_CTRL_COPY);
  wire       req_wr   = byte_strobe && wr_q && ctrl_hit && wr_byte[7];
  wire       mode_ok  = (wr_byte[6:4] == `MODE_ECB) || ((wr_byte[6:4] == `MODE_CBC) && !wr_byte[3]);
  wire       out_win  = (ptr_q < `ADDR_STATUS) || (ptr_q > `ADDR_CTRL_COPY);
  reg  [11:0] busy_cyc;

  // Cycles of the current run; the long bound is counted, not unrolled
  always @(posedge mclk)
  begin
    if (rst || sleep_state || !run_busy_q)
      busy_cyc <= 12'h000;
    else if (busy_cyc != 12'hFFF)
      busy_cyc <= busy_cyc + 12'h001;
  end

  // Shadow of the access pointer, so checks know which location a strobe hits
  always @(posedge mclk)
  begin
    if (rst || sleep_state)
      ptr_q <= 8'h00;
    else if (acc_begin)
      ptr_q <= acc_addr;
    else if (byte_strobe)
      ptr_q <= ptr_q + 8'h01;
    if (acc_begin)
      wr_q <= acc_write;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || sleep_state);

  reset_clear_a: assert property (disable iff (sleep_state)
    rst |=> !run_busy_q && !run_done_q && (rd_byte_q == 8'h00)) else $error("reset left state");
  sleep_clear_a: assert property (disable iff (rst)
    sleep_state |=> (rd_byte_q == 8'h00) && !run_busy_q && !run_done_q) else $error("sleep access");
  run_bound_a: assert property (busy_cyc <= `RUN_MAX_CYCLES)
    else $error("run too long");
  done_on_end_a: assert property (
    $fell(run_busy_q) && !$past(rst) && !$past(sleep_state) |-> run_done_q) else $error("no done");
  start_clears_a: assert property ($rose(run_busy_q) |-> !run_done_q)
    else $error("done kept at start");
  rd_hold_a: assert property (!byte_strobe |=> $stable(rd_byte_q))
    else $error("read byte moved");
  window_out_a: assert property (byte_strobe && out_win |=> rd_byte_q == 8'h00)
    else $error("outside window answered");
  start_src_a: assert property ($rose(run_busy_q) |-> $past(req_wr))
    else $error("run without request");
  start_ok_a: assert property (req_wr && mode_ok && !run_busy_q |=> run_busy_q)
    else $error("request not taken");
  start_bad_a: assert property (req_wr && !mode_ok && !run_busy_q |=> !run_busy_q)
    else $error("bad mode started");
endmodule // cipher_control_checker

bind cipher_control cipher_control_checker u_chk (.mclk(mclk), .rst(rst),
  .sleep_state(sleep_state), .acc_begin(acc_begin), .acc_addr(acc_addr),
  .acc_write(acc_write), .byte_strobe(byte_strobe), .wr_byte(wr_byte),
  .rd_byte_q(rd_byte_q), .run_busy_q(run_busy_q), .run_done_q(run_done_q));

// ### tb/cipher_control_tb.sv
// Testbench: table-driven cipher runs, then hand-written edge cases
`timescale 1ns/1ps
`include "cipher_consts.vh"

module cipher_control_tb;
  localparam logic [127:0] KEY0 = 128'h000102030405060708090A0B0C0D0E0F;
  localparam logic [127:0] PT   = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] CT   = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
  localparam logic [127:0] KLST = 128'h13111D7FE3944A17F307A78B4D2B30C5;

  typedef struct { logic [127:0] key; logic [7:0] ctrl; logic [127:0] blk; logic [127:0] exp; } row_t;

  logic       mclk;
  logic       rst;
  logic       sleep_state;
  logic       acc_begin;
  logic [7:0] acc_addr;
  logic       acc_write;
  logic       byte_strobe;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte_q;
  logic       run_busy_q;
  logic       run_done_q;
  int         err_total;
  int         checks;
  row_t       rows [3];

  cipher_control u_dut (.mclk(mclk), .rst(rst), .sleep_state(sleep_state),
    .acc_begin(acc_begin), .acc_addr(acc_addr), .acc_write(acc_write),
    .byte_strobe(byte_strobe), .wr_byte(wr_byte), .rd_byte_q(rd_byte_q),
    .run_busy_q(run_busy_q), .run_done_q(run_done_q));

  host_model u_host (.mclk(mclk), .acc_begin(acc_begin), .acc_addr(acc_addr),
    .acc_write(acc_write), .byte_strobe(byte_strobe), .wr_byte(wr_byte),
    .rd_byte_q(rd_byte_q));

  // 100 MHz clock, always running since the host keeps the clock output enabled
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [159:0] seen, input logic [159:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Bounded wait; a run that never ends shows up as a mismatch
  task automatic wait_idle;
    int n;
    n = 0;
    while (run_busy_q !== 1'b0 && n < 3000)
    begin
      @(negedge mclk);
      n++;
    end
    check("run end", run_busy_q, 1'b0);
  endtask

  // Mode, block and start through the copy location in one access
  task automatic run_blk(input logic [7:0] ctrl, input logic [127:0] blk, output logic [127:0] old);
    logic [159:0] rb;
    u_host.access(`ADDR_CTRL, 1'b1, 18, {ctrl, blk, ctrl | 8'h80, 16'h0000}, rb);
    old = rb[135:8];
    wait_idle();
  endtask

  task automatic read_n(input logic [7:0] addr, input int n, output logic [159:0] rb);
    u_host.access(addr, 1'b0, n, 160'h0, rb);
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #50000;
    err_total++;
    tally_and_finish();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [159:0] rb;
    logic [127:0] old;
    logic [7:0]   bad [2];
    err_total   = 0;
    checks      = 0;
    rst         = 1'b1;
    sleep_state = 1'b0;
    rows[0] = '{KEY0, 8'h00, PT, CT};      // ECB encrypt
    rows[1] = '{KEY0, 8'h20, PT ^ CT, CT}; // CBC: chained with the previous result
    rows[2] = '{KLST, 8'h08, CT, PT};      // ECB decrypt with the last round key
    bad[0]  = 8'h90;
    bad[1]  = 8'hA8;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    for (int r = 0; r < 3; r++)
    begin
      u_host.load_key(rows[r].key);
      run_blk(rows[r].ctrl, rows[r].blk, old);
      read_n(`ADDR_BLK_FIRST, 16, rb);
      check("result", rb[127:0], rows[r].exp);
      $display("Row %0d done", r);
    end
    // Key page shows the last round key; stored key and fast readback stay right
    u_host.load_key(KEY0);
    run_blk(8'h00, PT, old);
    u_host.access(`ADDR_CTRL, 1'b1, 1, {8'h10, 152'h0}, rb);
    read_n(`ADDR_BLK_FIRST, 16, rb);
    check("last round key", rb[127:0], KLST);
    run_blk(8'h00, PT, old);
    check("fast readback", old, CT);
    read_n(`ADDR_BLK_FIRST, 16, rb);
    check("key kept", rb[127:0], CT);
    read_n(`ADDR_STATUS, 2, rb);
    check("status and request", rb[15:0], 16'h0100);
    $display("Key test done");
    // Key mode and CBC decrypt must not start
    for (int i = 0; i < 2; i++)
    begin
      u_host.access(`ADDR_CTRL, 1'b1, 1, {bad[i], 152'h0}, rb);
      check("refused busy", run_busy_q, 1'b0);
      read_n(`ADDR_STATUS, 1, rb);
      check("error bit", rb[1], 1'b1);
    end
    $display("Refusal test done");
    // Outside the window nothing is stored and zero comes back
    u_host.access(8'h81, 1'b1, 1, {8'hFF, 152'h0}, rb);
    read_n(8'h81, 1, rb);
    check("outside", rb[7:0], 8'h00);
    // Start by the control location itself
    u_host.access(`ADDR_CTRL, 1'b1, 17, {8'h00, PT, 24'h0}, rb);
    u_host.access(`ADDR_CTRL, 1'b1, 1, {8'h80, 152'h0}, rb);
    check("start at control", run_busy_q, 1'b1);
    wait_idle();
    check("done flag", run_done_q, 1'b1);
    read_n(`ADDR_BLK_FIRST, 16, rb);
    check("control start result", rb[127:0], CT);
    $display("Window test done");
    // Sleep refuses access and wipes everything
    sleep_state = 1'b1;
    read_n(`ADDR_BLK_FIRST, 2, rb);
    check("sleep read", rb[15:0], 16'h0000);
    sleep_state = 1'b0;
    read_n(`ADDR_STATUS, 18, rb);
    check("after sleep", rb[143:0], 144'h0);
    // Reset in mid-run
    u_host.access(`ADDR_CTRL, 1'b1, 1, {8'h80, 152'h0}, rb);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    check("reset busy", run_busy_q, 1'b0);
    check("reset done", run_done_q, 1'b0);
    $display("Sleep and reset test done");
    tally_and_finish();
  end
endmodule // cipher_control_tb
